/* pgl_control.sv */
`timescale 1ns/100ps

// Operation
// (R1) Masks gate only line assertion, nothing else
// (R2) Line-type bit selects output-only or bidirectional
// (R3) Line type fixed before first regulator enable
// (R4) Line type same in secure and programmable
// (R5) Output-only mode ignores sensed line level
// (R6) Float line only when supplies all good
// (R7) Hold line low after power-up
// (R8) Enable starts regulators, Regulation, releases line
// (R9) Output-only: stay in Regulation once high
// (R10) Not-good after high drives and latches low
// (R11) Bidirectional input active only after enable
// (R12) Bidirectional mode requires enable pin grounded
// (R13) Bidirectional: Regulation to monitor when high
// (R14) Host holds line low minimum pulse time
// (R15) Secure pulse: sequence off, low, unlock bit
// (R16) Secure shutdown keeps locks except enable bit
// (R17) Secure bus enable: sequence on, relock
// (R18) Programmable pulse: sequence off, line low
// (R19) Programmable enable bit write sequences on
// (R20) Synchronised input, parameterised minimum low count
module pgl_control #(
  parameter int MIN_LOW_CYCLES = pgl_pkg::MIN_LOW_PULSE_CYCLES,
  parameter int STEP_LEN = pgl_pkg::STEP_CYCLES
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic programmable_mode_in,
  input wire logic line_type_wr_in,
  input wire logic line_type_val_in,
  input wire logic regulator_enable_pin_in,
  input wire logic bus_enable_wr_in,
  input wire logic bus_enable_val_in,
  input wire logic bus_disable_in,
  input wire logic bulk_input_supply_ok_in,
  input wire logic [4:0] rail_enabled_in,
  input wire logic [4:0] rail_in_tol_in,
  input wire logic pg_mask_in,
  input wire logic latch_clear_in,
  input wire logic power_ok_line_in,
  output logic power_ok_line_out,
  output logic power_ok_line_oe_n_out,
  output logic line_type_out,
  output logic enable_bit_unlocked_out,
  output logic power_not_good_out,
  output logic pg_latched_out,
  output logic rails_on_out,
  output logic seq_busy_out,
  output logic [1:0] seq_step_out,
  output logic link_disable_event_out,
  output logic [2:0] state_out
);

  ////////////////////////////////////////////////////////////////////////////////

  pgl_pkg::pgl_state_type state_q, state_d;
  logic line_type_q, line_type_d;
  logic type_frozen_q, type_frozen_d;
  logic unlock_q, unlock_d;
  logic latch_q, latch_d;
  logic seen_high_q, seen_high_d;
  logic drive_low_q, drive_low_d;
  logic not_good_q;
  logic sync1_q, sync2_q;
  logic [15:0] low_cnt_q, low_cnt_d;
  logic pulse_q, pulse_d;
  logic unlocked_q;
  logic pin_sync1_q, pin_sync2_q;
  logic bulk_sync1_q, bulk_sync2_q;

  pgl_seq_if sq ();

  pgl_sequencer #(
    .STEP_LEN(STEP_LEN)
  ) u_seq (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .sq(sq)
  );

  ////////////////////////////////////////////////////////////////////////////////

  // Rail supervision: only enabled rails count, bulk supply must be valid.
  wire rails_bad = |(rail_enabled_in & ~rail_in_tol_in);
  wire supply_good = bulk_sync2_q && !rails_bad; // (R6)
  wire line_high = sync2_q;
  wire secure_mode = !programmable_mode_in;
  wire operating = (state_q == pgl_pkg::PGL_REGULATION) || (state_q == pgl_pkg::PGL_LINK_MONITOR);
  // Enable pin is only honoured in output-only mode; bus enable in both.
  wire pin_enable = pin_sync2_q && !line_type_q; // (R12)
  wire prog_bit_enable = bus_enable_wr_in && bus_enable_val_in;
  wire secure_bit_enable = prog_bit_enable && (programmable_mode_in || unlock_q || !type_frozen_q);
  wire enable_cmd = pin_enable || secure_bit_enable;
  // Input function only in bidirectional mode after enable.
  wire input_active = line_type_q && type_frozen_q && operating; // (R5) (R11)
  wire low_seen = input_active && !line_high;
  wire pulse_ok = low_seen && (low_cnt_q >= 16'(MIN_LOW_CYCLES - 1)); // (R20)
  wire disable_req = pulse_ok && !pulse_q;
  wire latch_set = seen_high_q && operating && !supply_good; // (R10)
  // Before the line has been seen high, a bad supply still keeps it from floating.
  wire early_bad = (state_q == pgl_pkg::PGL_REGULATION) && !seen_high_q && not_good_q; // (R6)

  ////////////////////////////////////////////////////////////////////////////////

  // Two-flop synchroniser on the shared line.
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end else begin
      sync1_q <= power_ok_line_in;
      sync2_q <= sync1_q; // (R20)
    end
  end

  // The enable pin and the bulk-supply flag come from outside this clock domain.
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      pin_sync1_q <= 1'b0;
      pin_sync2_q <= 1'b0;
      bulk_sync1_q <= 1'b0;
      bulk_sync2_q <= 1'b0;
    end else begin
      pin_sync1_q <= regulator_enable_pin_in;
      pin_sync2_q <= pin_sync1_q;
      bulk_sync1_q <= bulk_input_supply_ok_in;
      bulk_sync2_q <= bulk_sync1_q;
    end
  end

  // Low-level persistence counter; one event per low pulse.
  always_comb begin
    low_cnt_d = 16'h0000;
    pulse_d = 1'b0;
    if (low_seen) begin
      pulse_d = pulse_q || pulse_ok;
      if (low_cnt_q != 16'hFFFF) begin
        low_cnt_d = low_cnt_q + 16'h0001;
      end else begin
        low_cnt_d = low_cnt_q;
      end
    end
  end

  // Line type writable only until the first enable; same in both modes.
  always_comb begin
    line_type_d = line_type_q;
    type_frozen_d = type_frozen_q || enable_cmd;
    if (line_type_wr_in && !type_frozen_q) begin // (R3)
      line_type_d = line_type_val_in; // (R2) (R4)
    end
  end

  // Main operating state.
  always_comb begin
    state_d = state_q;
    sq.start_on = 1'b0;
    sq.start_off = 1'b0;
    unlock_d = unlock_q;
    seen_high_d = seen_high_q;
    drive_low_d = drive_low_q;
    case (state_q)
      pgl_pkg::PGL_IDLE, pgl_pkg::PGL_OFF: begin
        drive_low_d = 1'b1; // (R7)
        if (enable_cmd && !sq.busy) begin
          sq.start_on = 1'b1; // (R8) (R17) (R19)
          state_d = pgl_pkg::PGL_SEQ_ON;
        end
      end
      pgl_pkg::PGL_SEQ_ON: begin
        if (sq.done) begin
          state_d = pgl_pkg::PGL_REGULATION;
          drive_low_d = 1'b0; // (R8)
          seen_high_d = 1'b0;
          if (secure_mode) begin
            unlock_d = 1'b0; // (R17)
          end
        end
      end
      pgl_pkg::PGL_REGULATION: begin
        if (line_high && !drive_low_q) begin
          seen_high_d = 1'b1; // (R9)
          if (line_type_q) begin
            state_d = pgl_pkg::PGL_LINK_MONITOR; // (R13)
          end
        end
      end
      pgl_pkg::PGL_LINK_MONITOR: begin
        if (disable_req) begin
          sq.start_off = 1'b1; // (R15) (R18)
          drive_low_d = 1'b1;
          state_d = pgl_pkg::PGL_SEQ_OFF;
          if (secure_mode) begin
            unlock_d = 1'b1; // (R15) (R16)
          end
        end
      end
      pgl_pkg::PGL_SEQ_OFF: begin
        drive_low_d = 1'b1;
        if (sq.done) begin
          state_d = pgl_pkg::PGL_OFF;
        end
      end
      default: begin
        state_d = pgl_pkg::PGL_IDLE;
      end
    endcase
    if (bus_disable_in && operating) begin
      sq.start_off = 1'b1;
      drive_low_d = 1'b1;
      state_d = pgl_pkg::PGL_SEQ_OFF;
    end
  end

  // Latched not-good: set wins over a same-cycle clear.
  always_comb begin
    latch_d = latch_q;
    if (latch_clear_in) begin
      latch_d = 1'b0;
    end
    if (latch_set) begin
      latch_d = 1'b1; // (R10)
    end
    if (state_q == pgl_pkg::PGL_OFF || state_q == pgl_pkg::PGL_SEQ_ON) begin
      latch_d = 1'b0;
    end
  end

  // Operating state and the lock of the bus-enable bit.
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      state_q <= pgl_pkg::PGL_IDLE;
      unlock_q <= pgl_pkg::RST_ENABLE_LOCK;
      unlocked_q <= pgl_pkg::RST_ENABLE_LOCK;
      seen_high_q <= 1'b0;
      drive_low_q <= 1'b1;
    end else begin
      state_q <= state_d;
      unlock_q <= unlock_d;
      unlocked_q <= unlock_d || programmable_mode_in; // (R16)
      seen_high_q <= seen_high_d;
      drive_low_q <= drive_low_d;
    end
  end

  // Line type and its freeze at the first enable.
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      line_type_q <= pgl_pkg::RST_LINE_TYPE;
      type_frozen_q <= 1'b0;
    end else begin
      line_type_q <= line_type_d;
      type_frozen_q <= type_frozen_d;
    end
  end

  // Latched not-good.
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      latch_q <= 1'b0;
    end else begin
      latch_q <= latch_d;
    end
  end

  // Supply status, one cycle behind the rail detectors and three behind the bulk-supply flag.
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      not_good_q <= 1'b1;
    end else begin
      not_good_q <= !supply_good; // (R1) (R7)
    end
  end

  // Low-pulse detector.
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      low_cnt_q <= 16'h0000;
      pulse_q <= 1'b0;
    end else begin
      low_cnt_q <= low_cnt_d;
      pulse_q <= pulse_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  // The mask gates only the pin; status and shutdown keep working.
  wire pin_low = drive_low_q || ((latch_q || early_bad) && !pg_mask_in); // (R1) (R6)
  assign power_ok_line_out = 1'b0;
  assign power_ok_line_oe_n_out = !pin_low;
  assign line_type_out = line_type_q;
  assign enable_bit_unlocked_out = unlocked_q;
  assign power_not_good_out = not_good_q;
  assign pg_latched_out = latch_q;
  assign rails_on_out = sq.regs_on;
  assign seq_busy_out = sq.busy;
  assign seq_step_out = sq.step;
  assign link_disable_event_out = pulse_q;
  assign state_out = state_q;

endmodule

/* pgl_pkg.sv */
package pgl_pkg;

  // Power-on and power-off sequences run three steps, config0 through config2.
  localparam int SEQ_STEPS = 3;
  localparam logic [1:0] SEQ_LAST = 2'h2;
  // Cycles spent on each sequence step.
  localparam int STEP_CYCLES = 4;
  // Least low time on the shared line for a disable request.
  localparam int MIN_LOW_PULSE_NS = 1000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int MIN_LOW_PULSE_CYCLES = (MIN_LOW_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Values after reset.
  localparam logic RST_LINE_TYPE = 1'b0;
  localparam logic RST_ENABLE_LOCK = 1'b1;

  typedef enum logic [2:0] {
    PGL_IDLE,
    PGL_SEQ_ON,
    PGL_REGULATION,
    PGL_LINK_MONITOR,
    PGL_SEQ_OFF,
    PGL_OFF
  } pgl_state_type;

endpackage

/* pgl_seq_if.sv */
`timescale 1ns/100ps

interface pgl_seq_if;
  logic start_on;
  logic start_off;
  logic busy;
  logic done;
  logic regs_on;
  logic [1:0] step;

  modport ctrl (
    output start_on,
    output start_off,
    input busy,
    input done,
    input regs_on,
    input step
  );

  modport seq (
    input start_on,
    input start_off,
    output busy,
    output done,
    output regs_on,
    output step
  );
endinterface

/* pgl_sequencer.sv */
`timescale 1ns/100ps

module pgl_sequencer #(
  parameter int STEP_LEN = pgl_pkg::STEP_CYCLES
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  pgl_seq_if.seq sq
);

  logic busy_q, busy_d;
  logic dir_on_q, dir_on_d;
  logic on_q, on_d;
  logic [1:0] step_q, step_d;
  logic [15:0] cnt_q, cnt_d;
  logic done_q, done_d;

  wire step_end = (cnt_q == 16'(STEP_LEN - 1));
  wire last_step = (step_q == pgl_pkg::SEQ_LAST);

  // Walks steps config0..config2 in order; rails drop at the start of power-off and come on at the end of power-on.
  always_comb begin
    busy_d = busy_q;
    dir_on_d = dir_on_q;
    on_d = on_q;
    step_d = step_q;
    cnt_d = cnt_q;
    done_d = 1'b0;
    if (!busy_q && (sq.start_on || sq.start_off)) begin
      busy_d = 1'b1;
      dir_on_d = sq.start_on;
      step_d = 2'h0;
      cnt_d = 16'h0000;
      if (sq.start_off) begin
        on_d = 1'b0;
      end
    end else if (busy_q) begin
      if (step_end) begin
        cnt_d = 16'h0000;
        if (last_step) begin
          busy_d = 1'b0;
          done_d = 1'b1;
          on_d = dir_on_q;
        end else begin
          step_d = step_q + 2'h1;
        end
      end else begin
        cnt_d = cnt_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      busy_q <= 1'b0;
      dir_on_q <= 1'b0;
      on_q <= 1'b0;
      step_q <= 2'h0;
      cnt_q <= 16'h0000;
      done_q <= 1'b0;
    end else begin
      busy_q <= busy_d;
      dir_on_q <= dir_on_d;
      on_q <= on_d;
      step_q <= step_d;
      cnt_q <= cnt_d;
      done_q <= done_d;
    end
  end

  assign sq.busy = busy_q;
  assign sq.done = done_q;
  assign sq.regs_on = on_q;
  assign sq.step = step_q;

endmodule

/* pgl_control_asserts.sv */
`timescale 1ns/100ps

module pgl_control_asserts #(
  parameter int STEP_LEN = 4
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic programmable_mode_in,
  input wire logic bus_enable_wr_in,
  input wire logic bus_enable_val_in,
  input wire logic pg_mask_in,
  input wire logic power_ok_line_out,
  input wire logic power_ok_line_oe_n_out,
  input wire logic line_type_out,
  input wire logic enable_bit_unlocked_out,
  input wire logic power_not_good_out,
  input wire logic pg_latched_out,
  input wire logic seq_busy_out,
  input wire logic link_disable_event_out,
  input wire logic [2:0] state_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  logic ran_q;
  logic [7:0] busy_cnt_q;
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in || !seq_busy_out) busy_cnt_q <= 8'h00;
    else busy_cnt_q <= busy_cnt_q + 8'h01;
  end
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) ran_q <= 1'b0;
    else if (seq_busy_out) ran_q <= 1'b1;
  end
  chk_open_drain: assert property (power_ok_line_out == 1'b0) else $error("line data high");
  chk_idle_low: assert property (state_out == pgl_pkg::PGL_IDLE |-> !power_ok_line_oe_n_out)
    else $error("idle line released");
  chk_bad_low: assert property (power_not_good_out && !pg_mask_in |-> ##[0:1] !power_ok_line_oe_n_out)
    else $error("released while not good");
  chk_latch_low: assert property (pg_latched_out && !pg_mask_in |-> ##[0:1] !power_ok_line_oe_n_out)
    else $error("latch not driving line");
  chk_seq_start: assert property (bus_enable_wr_in && bus_enable_val_in && enable_bit_unlocked_out
    && (state_out == pgl_pkg::PGL_IDLE || state_out == pgl_pkg::PGL_OFF) |=> seq_busy_out)
    else $error("enable write ignored");
  chk_seq_len: assert property ($fell(seq_busy_out) |-> busy_cnt_q == 8'(3 * STEP_LEN))
    else $error("sequence length wrong");
  chk_type_frozen: assert property (ran_q |-> $stable(line_type_out)) else $error("type changed");
  chk_monitor_type: assert property (state_out == pgl_pkg::PGL_LINK_MONITOR |-> line_type_out)
    else $error("monitor in output-only");
  chk_type0_ignore: assert property (!line_type_out |-> !link_disable_event_out)
    else $error("input used in output-only");
  chk_unlock_off: assert property (state_out == pgl_pkg::PGL_SEQ_OFF |-> enable_bit_unlocked_out)
    else $error("enable bit locked");
  chk_relock_on: assert property (state_out == pgl_pkg::PGL_REGULATION && line_type_out
    && !programmable_mode_in |-> !enable_bit_unlocked_out) else $error("enable bit not relocked");
  chk_off_low: assert property (state_out == pgl_pkg::PGL_OFF |-> !power_ok_line_oe_n_out)
    else $error("off line released");
  chk_reg_float: assert property ($past(state_out) == pgl_pkg::PGL_SEQ_ON
    && state_out == pgl_pkg::PGL_REGULATION && !power_not_good_out |-> power_ok_line_oe_n_out)
    else $error("line not released");
endmodule

bind pgl_control pgl_control_asserts #(.STEP_LEN(STEP_LEN)) chk_u (.core_clk_in, .sys_rst_in,
  .programmable_mode_in, .bus_enable_wr_in, .bus_enable_val_in, .pg_mask_in, .power_ok_line_out,
  .power_ok_line_oe_n_out, .line_type_out, .enable_bit_unlocked_out, .power_not_good_out,
  .pg_latched_out, .seq_busy_out, .link_disable_event_out, .state_out);

/* pgl_line_model.sv */
`timescale 1ns/100ps

module pgl_line_model (
  input wire logic oe_n_in,
  input wire logic data_in,
  input wire logic host_low_in,
  input wire logic peer_low_in,
  output logic line_out
);
  // The pull-up wins only when no party pulls the wired line low.
  assign line_out = (oe_n_in | data_in) & ~host_low_in & ~peer_low_in;
endmodule

/* tb_top.sv */
`timescale 1ns/100ps

module tb_top;
  localparam int ML = 4;
  localparam logic [2:0] S_REG = pgl_pkg::PGL_REGULATION;
  localparam logic [2:0] S_MON = pgl_pkg::PGL_LINK_MONITOR;
  localparam logic [2:0] S_OFF = pgl_pkg::PGL_OFF;
  logic core_clk_in = 0;
  logic sys_rst_in = 1;
  logic pmode = 0, lt_wr = 0, lt_val = 0, pin = 0, be_wr = 0, bulk = 1;
  logic mask = 0, lclr = 0, host_low = 0, peer_low = 0, line, data, oe_n, lt, unl, png;
  logic [4:0] ren = 5'h1F, rtol = 5'h1F;
  logic [2:0] st;
  logic ron, lat;
  logic [1:0] stp;
  int bad_count = 0;
  int compares = 0;
  always #5 core_clk_in = ~core_clk_in;
  pgl_control #(.MIN_LOW_CYCLES(ML), .STEP_LEN(4)) dut_u (.core_clk_in, .sys_rst_in,
    .programmable_mode_in(pmode), .line_type_wr_in(lt_wr), .line_type_val_in(lt_val),
    .regulator_enable_pin_in(pin), .bus_enable_wr_in(be_wr), .bus_enable_val_in(be_wr),
    .bus_disable_in(1'b0), .bulk_input_supply_ok_in(bulk), .rail_enabled_in(ren),
    .rail_in_tol_in(rtol), .pg_mask_in(mask), .latch_clear_in(lclr), .power_ok_line_in(line),
    .power_ok_line_out(data), .power_ok_line_oe_n_out(oe_n), .line_type_out(lt),
    .enable_bit_unlocked_out(unl), .power_not_good_out(png), .pg_latched_out(lat), .rails_on_out(ron),
    .seq_busy_out(), .seq_step_out(stp), .link_disable_event_out(), .state_out(st));
  pgl_line_model line_u (.oe_n_in(oe_n), .data_in(data), .host_low_in(host_low),
    .peer_low_in(peer_low), .line_out(line));
  task automatic chk(string n, logic [2:0] e, logic [2:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge core_clk_in);
  endtask
  task automatic wait_st(logic [2:0] s);
    for (int i = 0; i < 200 && st !== s; i++) cyc(1);
    chk("state", s, st);
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    cyc(1);
    s = 0;
    cyc(1);
  endtask
  task automatic print_verdict;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #50000;
    bad_count++;
    print_verdict();
  end
  initial begin
    cyc(6);
    sys_rst_in = 0;
    chk("oe_n", 0, oe_n);
    chk("type", 0, lt);
    pin = 1;
    wait_st(S_REG);
    chk("oe_n", 1, oe_n);
    chk("ron", 1, ron);
    peer_low = 1;
    cyc(3 * ML);
    chk("state", S_REG, st);
    rtol = 5'h1E;
    cyc(3);
    chk("oe_n", 0, oe_n);
    peer_low = 0;
    ren = 5'h0F;
    rtol = 5'h0F;
    cyc(3);
    chk("oe_n", 1, oe_n);
    ren = 5'h1F;
    mask = 1;
    cyc(3);
    chk("png", 1, png);
    chk("oe_n", 1, oe_n);
    rtol = 5'h1F;
    pulse(lclr);
    mask = 0;
    rtol = 5'h1E;
    cyc(3);
    rtol = 5'h1F;
    cyc(5);
    chk("oe_n", 0, oe_n);
    chk("lat", 1, lat);
    pulse(lclr);
    cyc(2);
    chk("oe_n", 1, oe_n);
    chk("state", S_REG, st);
    lt_val = 1;
    pulse(lt_wr);
    chk("type", 0, lt);
    sys_rst_in = 1;
    pin = 0;
    cyc(6);
    sys_rst_in = 0;
    pulse(lt_wr);
    chk("type", 1, lt);
    pulse(be_wr);
    wait_st(S_MON);
    chk("unl", 0, unl);
    host_low = 1;
    cyc(2);
    host_low = 0;
    cyc(ML + 4);
    chk("state", S_MON, st);
    host_low = 1;
    wait_st(S_OFF);
    host_low = 0;
    chk("unl", 1, unl);
    chk("oe_n", 0, oe_n);
    chk("ron", 0, ron);
    chk("step", 2, stp);
    pulse(be_wr);
    wait_st(S_MON);
    chk("unl", 0, unl);
    pmode = 1;
    host_low = 1;
    wait_st(S_OFF);
    host_low = 0;
    chk("oe_n", 0, oe_n);
    pulse(be_wr);
    wait_st(S_MON);
    chk("oe_n", 1, oe_n);
    print_verdict();
  end
endmodule
